/* rtl/ras_cfg.svh */
// Offsets, field positions, reset values and sizes of the return address stack.
`ifndef RAS_CFG_SVH
`define RAS_CFG_SVH

// Register indices; the byte address on the bus is four times the index.
`define RAS_IDX_PTR      8'hDF
`define RAS_IDX_ENT_BASE 8'hF0
`define RAS_IDX_ENT_LAST 8'hFF

// Stack geometry.
`define RAS_DEPTH        4
`define RAS_PC_W         11
`define RAS_PCH_W        3
`define RAS_PCL_W        8
`define RAS_PTR_W        3

// Pointer register fields.
`define RAS_GIE_BIT      7
`define RAS_PTR_LSB      0
`define RAS_PTR_MSB      2

// Pointer codes: empty, top entry in use, overflow.
`define RAS_PTR_EMPTY    3'h7
`define RAS_PTR_FULL     3'h3
`define RAS_PTR_OVER     3'h2

// Reset values.
`define RAS_RST_GIE      1'b0
`define RAS_RST_PTR      3'h7
`define RAS_RST_PC       11'h000

`endif

/* rtl/ras_pkg.sv */
// Types shared by the return address stack.
package ras_pkg;

  typedef logic [2:0]  ras_ptr_t;
  typedef logic [10:0] ras_pc_t;
  typedef logic [1:0]  ras_idx_t;

  typedef enum logic [1:0]
  {
    RAS_BUS_IDLE  = 2'b00,
    RAS_BUS_WRITE = 2'b01,
    RAS_BUS_RWAIT = 2'b10,
    RAS_BUS_RDONE = 2'b11
  } ras_bus_e;

endpackage

/* rtl/ras_top.sv */
// Four level return address stack with an AHB-Lite register port.
//
// The implementer's own choice: register access over AHB-Lite.
`include "ras_cfg.svh"

// Function
// RQ1: Four stack entries hold return addresses, used last in first out.
// RQ2: A three bit level pointer selects the entry for each push or pop.
// RQ3: Each entry holds a saved counter as a 3-bit high and 8-bit low part.
// RQ4: A push decrements the pointer and a pop increments it.
// RQ5: Call and interrupt entry write the counter into the selected entry.
// RQ6: Subroutine or interrupt return pops and returns the latest saved counter.
// RQ7: Pointer 111 is empty; pushes walk 110, 101, 100, 011 using entries 0 to 3.
// RQ8: Bit 7 is the interrupt enable, reset 0; pointer bits reset to ones.
// RQ9: Pointer and entries are reachable by software at fixed addresses.
// RQ10: Software should write all ones to the pointer at program start.
// RQ11: The full eleven bit counter goes into and comes back from the stack.
// RQ12: A fifth push moves the pointer to 010 and stores nothing.
module ras_top
#(
  parameter int ADDR_W = 12
)
(
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [ADDR_W-1:0]    haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 call_push,
  input  wire logic                 irq_push,
  input  wire logic [10:0]          push_pc,
  input  wire logic                 sub_exit_op,
  input  wire logic                 irq_exit_op,
  output logic      [10:0]          pop_pc,
  output logic                      pop_valid,
  output logic                      global_irq_enable,
  output logic      [2:0]           stack_level_pointer,
  output logic                      stack_overflow
);

  initial
  begin
    if (ADDR_W < 10)
      $error("ras_top: ADDR_W must be at least 10");
  end

  // Maps a pointer code to the entry that a push at that code fills.
  function automatic ras_pkg::ras_idx_t push_slot(input ras_pkg::ras_ptr_t p);
    push_slot = ~p[1:0];
  endfunction

  // Stack state.
  ras_pkg::ras_pc_t   entry_q [`RAS_DEPTH];
  ras_pkg::ras_ptr_t  ptr_q;
  ras_pkg::ras_ptr_t  ptr_d;
  logic               gie_q;
  logic               gie_d;
  ras_pkg::ras_pc_t   pop_pc_q;
  logic               pop_valid_q;

  // Bus state.
  ras_pkg::ras_bus_e  bus_q;
  ras_pkg::ras_bus_e  bus_d;
  logic [7:0]         reg_idx_q;
  logic               idx_hi_ok_q;
  logic [31:0]        hrdata_q;

  // Core side decode.
  wire                push_req   = call_push | irq_push;
  wire                pop_req    = (sub_exit_op | irq_exit_op) & ~push_req;
  wire                is_empty   = (ptr_q == `RAS_PTR_EMPTY);
  wire                is_over    = (ptr_q == `RAS_PTR_OVER);
  wire                can_store  = ptr_q[2];
  wire                push_go    = push_req & ~is_over;
  wire                pop_go     = pop_req & ~is_empty;
  wire [2:0]          ptr_up     = 3'(ptr_q + 3'h1);
  wire [2:0]          ptr_down   = 3'(ptr_q - 3'h1);
  wire [1:0]          wr_slot    = push_slot(ptr_q);
  wire [1:0]          rd_slot    = is_over ? 2'(`RAS_DEPTH - 1) : push_slot(ptr_up);

  // Bus side decode.
  wire                addr_take  = hsel & htrans[1] & hready;
  wire [7:0]          addr_idx   = haddr[9:2];
  wire                addr_hi_ok = (haddr >> 10) == '0;
  wire                sel_ptr    = idx_hi_ok_q & (reg_idx_q == `RAS_IDX_PTR);
  wire                sel_ent    = idx_hi_ok_q & (reg_idx_q >= `RAS_IDX_ENT_BASE)
                                   & (reg_idx_q <= `RAS_IDX_ENT_LAST);
  wire [1:0]          ent_slot   = reg_idx_q[2:1];
  wire                ent_high   = reg_idx_q[0];
  wire                ent_live   = (reg_idx_q[3] == 1'b0);
  wire                wr_now     = (bus_q == ras_pkg::RAS_BUS_WRITE);
  wire                sw_ptr_wr  = wr_now & sel_ptr;
  wire                sw_ent_wr  = wr_now & sel_ent & ent_live;
  wire [10:0]         sw_ent_val = ent_high
                                   ? {hwdata[2:0], entry_q[ent_slot][7:0]}
                                   : {entry_q[ent_slot][10:8], hwdata[7:0]};

  // Read data mux: unused upper entry addresses and reserved bits read zero.
  wire [31:0]         rd_ptr_val = {24'h000000, gie_q, 4'h0, ptr_q};
  wire [31:0]         rd_ent_val = !ent_live ? 32'h00000000
                                   : ent_high ? {29'h00000000, entry_q[ent_slot][10:8]}
                                   : {24'h000000, entry_q[ent_slot][7:0]};
  wire [31:0]         rd_mux     = sel_ptr ? rd_ptr_val
                                   : sel_ent ? rd_ent_val
                                   : 32'h00000000;

  // Pointer and enable next state; a core push or pop beats a software write of the pointer bits.
  always_comb
  begin
    ptr_d = ptr_q;
    gie_d = gie_q;
    if (sw_ptr_wr)
    begin
      gie_d = hwdata[`RAS_GIE_BIT];                            // RQ8
      ptr_d = hwdata[`RAS_PTR_MSB:`RAS_PTR_LSB];               // RQ9
    end
    if (push_go)
      ptr_d = ptr_down;                                        // RQ4 RQ7 RQ12
    else if (pop_go)
      ptr_d = ptr_up;                                          // RQ4
  end

  // Bus sequencer: reads take one wait state so read data leave a flip-flop.
  always_comb
  begin
    bus_d = ras_pkg::RAS_BUS_IDLE;
    unique case (bus_q)
      ras_pkg::RAS_BUS_RWAIT:
        bus_d = ras_pkg::RAS_BUS_RDONE;
      ras_pkg::RAS_BUS_IDLE,
      ras_pkg::RAS_BUS_WRITE,
      ras_pkg::RAS_BUS_RDONE:
        if (addr_take)
          bus_d = hwrite ? ras_pkg::RAS_BUS_WRITE : ras_pkg::RAS_BUS_RWAIT;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_q       <= ras_pkg::RAS_BUS_IDLE;
      reg_idx_q   <= 8'h00;
      idx_hi_ok_q <= 1'b0;
      hrdata_q    <= 32'h00000000;
    end
    else
    begin
      bus_q <= bus_d;
      if (addr_take)
      begin
        reg_idx_q   <= addr_idx;
        idx_hi_ok_q <= addr_hi_ok;
      end
      if (bus_q == ras_pkg::RAS_BUS_RWAIT)
        hrdata_q <= rd_mux;                                    // RQ9
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ptr_q <= `RAS_RST_PTR;                                   // RQ8
      gie_q <= `RAS_RST_GIE;                                   // RQ8
    end
    else
    begin
      ptr_q <= ptr_d;                                          // RQ2
      gie_q <= gie_d;
    end
  end

  // Entries: a push stores the whole counter; overflow pushes store nothing.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < `RAS_DEPTH; i++)
        entry_q[i] <= `RAS_RST_PC;                             // RQ1 RQ3
    end
    else
    begin
      if (sw_ent_wr)
        entry_q[ent_slot] <= sw_ent_val;                       // RQ3 RQ9
      if (push_go && can_store)
        entry_q[wr_slot] <= push_pc;                           // RQ5 RQ7 RQ11 RQ12
    end
  end

  // Return path: the latest saved counter comes back one cycle after a pop.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pop_pc_q    <= `RAS_RST_PC;
      pop_valid_q <= 1'b0;
    end
    else
    begin
      pop_valid_q <= pop_go;                                   // RQ6
      if (pop_go)
        pop_pc_q <= entry_q[rd_slot];                          // RQ1 RQ6 RQ11
    end
  end

  assign hrdata              = hrdata_q;
  assign hreadyout           = (bus_q != ras_pkg::RAS_BUS_RWAIT);
  assign hresp               = 1'b0;
  assign pop_pc              = pop_pc_q;
  assign pop_valid           = pop_valid_q;
  assign global_irq_enable   = gie_q;
  assign stack_level_pointer = ptr_q;
  assign stack_overflow      = is_over;                        // RQ12

endmodule

/* tb/ras_core_model.sv */
// Core sequencer model that issues pushes and pops.
module ras_core_model
(
  input  wire logic        hclk,
  output logic             call_push,
  output logic             irq_push,
  output logic      [10:0] push_pc,
  output logic             sub_exit_op,
  output logic             irq_exit_op
);
  initial
  begin
    {call_push, irq_push, sub_exit_op, irq_exit_op} = 4'h0;
    push_pc = 11'h2AA;
  end
  // One cycle of requests; outside a push the counter bus toggles.
  task automatic op(input logic [3:0] s, input logic [10:0] pc);
    {call_push, irq_push, sub_exit_op, irq_exit_op} <= s;
    push_pc <= (s[3] | s[2]) ? pc : ~push_pc;
    @(posedge hclk);
  endtask
endmodule

/* tb/ras_top_chk.sv */
// Concurrent checks on the return address stack ports.
module ras_top_chk
(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       call_push,
  input wire logic       irq_push,
  input wire logic       sub_exit_op,
  input wire logic       irq_exit_op,
  input wire logic       pop_valid,
  input wire logic [2:0] stack_level_pointer,
  input wire logic       stack_overflow
);
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  wire       psh = call_push | irq_push;
  wire       pop = (sub_exit_op | irq_exit_op) & !psh;
  wire [2:0] p   = stack_level_pointer;
  sequence s_take;
    hsel && htrans[1] && hready;
  endsequence
  property p_push; psh && p != 3'h2 |=> p == $past(p) - 3'h1 && !pop_valid; endproperty
  a_push: assert property (p_push) else $error("push step wrong");
  property p_pop; pop && p != 3'h7 |=> p == $past(p) + 3'h1 && pop_valid; endproperty
  a_pop: assert property (p_pop) else $error("pop step wrong");
  property p_empty; pop && p == 3'h7 |=> p == 3'h7 && !pop_valid; endproperty
  a_empty: assert property (p_empty) else $error("pop at empty acted");
  property p_ovf; stack_overflow == (p == 3'h2); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
  property p_sat; psh && p == 3'h2 |=> p == 3'h2; endproperty
  a_sat: assert property (p_sat) else $error("push past overflow moved");
  property p_valid; pop_valid |-> $past(pop && p != 3'h7); endproperty
  a_valid: assert property (p_valid) else $error("stray pop valid");
  property p_rd; s_take ##0 !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd: assert property (p_rd) else $error("read wait wrong");
  property p_wr; s_take ##0 hwrite |=> hreadyout; endproperty
  a_wr: assert property (p_wr) else $error("write stalled");
endmodule
bind ras_top ras_top_chk u_chk (.*);

/* tb/tb.sv */
// Testbench for the return address stack.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, stack_level_pointer;
  logic [31:0] hwdata, hrdata, r;
  logic        call_push, irq_push, sub_exit_op, irq_exit_op, pop_valid;
  logic        global_irq_enable, stack_overflow;
  logic [10:0] push_pc, pop_pc;
  logic [10:0] pcs [4] = '{11'h7A5, 11'h0C3, 11'h5F0, 11'h31E};
  wire         hready = hreadyout;
  int          mismatches, comparisons;
  ras_top u_ras_top (.*);
  ras_core_model core (.*);
  initial
  begin
    hclk = 0;
    forever #5 hclk = ~hclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    chk(n, e, r);
  endtask
  task automatic t_reset;
    rd("pointer reg", 12'h37C, 32'h07);
    rd("entry high", 12'h3C4, 32'h0);
    chk("irq enable", 0, global_irq_enable);
    chk("response", 0, hresp);
  endtask
  task automatic t_regs;
    bus(1'b1, 12'h37C, 8'hFD);
    rd("pointer reg", 12'h37C, 32'h85);
    chk("irq enable", 1, global_irq_enable);
    bus(1'b1, 12'h37C, 8'h07);
    bus(1'b1, 12'h3D8, 8'hA5);
    rd("entry low", 12'h3D8, 32'hA5);
    bus(1'b1, 12'h3DC, 8'hFF);
    rd("entry high", 12'h3DC, 32'h07);
    bus(1'b1, 12'h3E0, 8'h5A);
    rd("unmapped", 12'h3E0, 32'h0);
  endtask
  task automatic t_stack;
    for (int i = 0; i < 4; i++)
    begin
      core.op({~i[0], i[0], 2'b00}, pcs[i]);
      #1 chk("pointer", 6 - i, stack_level_pointer);
    end
    core.op(4'h0, 11'h0);
    for (int i = 0; i < 4; i++)
    begin
      rd("entry low", 12'h3C0 + 12'(8 * i), {24'h0, pcs[i][7:0]});
      rd("entry high", 12'h3C4 + 12'(8 * i), {29'h0, pcs[i][10:8]});
    end
    for (int i = 3; i >= 0; i--)
    begin
      core.op({2'b00, i[0], ~i[0]}, 11'h0);
      #1 chk("popped", pcs[i], pop_pc);
      chk("pop valid", 1, pop_valid);
      chk("pointer", 7 - i, stack_level_pointer);
    end
    core.op(4'h1, 11'h0);
    #1 chk("pop valid", 0, pop_valid);
    core.op(4'hA, 11'h1B2);
    #1 chk("pointer", 6, stack_level_pointer);
    core.op(4'h2, 11'h0);
    #1 chk("popped", 11'h1B2, pop_pc);
    for (int i = 0; i < 5; i++)
      core.op(4'h8, 11'h100 + 11'(i));
    core.op(4'h4, 11'h7FF);
    #1 chk("pointer", 2, stack_level_pointer);
    chk("overflow", 1, stack_overflow);
    core.op(4'h0, 11'h0);
    rd("entry low", 12'h3D8, 32'h03);
    bus(1'b1, 12'h37C, 8'h07);
    rd("pointer reg", 12'h37C, 32'h07);
  endtask
  task automatic results;
    if (mismatches == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_regs;
    t_stack;
    results;
  end
  initial
  begin
    repeat (3000) @(posedge hclk);
    mismatches++;
    results;
  end
endmodule
